// file: sim/gpp_gpio_pint_asserts.sv
// checker for the gpio port and pin interrupt block
`timescale 1ns/1ps
module gpp_gpio_pint_asserts #(
  parameter int NUM_PORTS = 2,
  parameter int NUM_CH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire gpp_pkg::gpp_acc_t wr, // write access
  input wire gpp_pkg::gpp_acc_t rd, // read access
  input wire logic rd_valid, // read answer
  input wire logic [NUM_PORTS*32-1:0] pin_out, // pad outputs
  input wire logic [NUM_PORTS*32-1:0] pin_oe, // pad enables
  input wire logic [NUM_CH-1:0] pint_irq, // channel lines
  input wire logic pm_evt_en, // event enable
  input wire logic cpu_event_notify, // event pulse
  input wire logic event_pin, // event pad copy
  input wire logic group_irq, // group interrupt
  input wire gpp_pkg::gpp_pwr_t power_mode, // power mode
  input wire logic wake_en, // wake enable
  input wire logic wake_req // wake request
);
  import gpp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // full-word write taken on port 0
  logic full_w;
  assign full_w = ce && wr.en && wr.port == 1'b0 && wr.be == 4'hF;
  // read handshake
  AST_RD_ANS: assert property (ce && rd.en |=> rd_valid) else $error("read not answered");
  AST_RD_ONE: assert property (ce && !rd.en |=> !rd_valid) else $error("read valid without read");
  // output writes
  AST_SET: assert property (full_w && wr.loc == GPP_LOC_SET |=>
    pin_out[31:0] == ($past(pin_out[31:0]) | $past(wr.data))) else $error("set write wrong");
  AST_CLR: assert property (full_w && wr.loc == GPP_LOC_CLR |=>
    pin_out[31:0] == ($past(pin_out[31:0]) & ~$past(wr.data))) else $error("clear write wrong");
  AST_OUT: assert property (full_w && wr.loc == GPP_LOC_OUT |=> pin_out[31:0] == $past(wr.data))
    else $error("port write wrong");
  // direction only moves on direction writes
  AST_DIR: assert property (full_w && wr.loc == GPP_LOC_DIR |=> pin_oe[31:0] == $past(wr.data))
    else $error("direction write wrong");
  AST_DIR_HOLD: assert property (!(ce && wr.en && wr.loc == GPP_LOC_DIR) |=> $stable(pin_oe))
    else $error("direction moved");
  // wake and event
  AST_WAKE: assert property (wake_req == (wake_en && (|pint_irq) &&
    (power_mode == GPP_PM_IDLE || power_mode == GPP_PM_STANDBY))) else $error("wake wrong");
  AST_EVT_PIN: assert property (event_pin == cpu_event_notify) else $error("event pad differs");
  AST_EVT_EN: assert property (ce && !pm_evt_en |=> !cpu_event_notify) else $error("event while off");
  // main scenarios reached
  COV_EVT: cover property (cpu_event_notify);
  COV_WAKE: cover property (wake_req);
  COV_GRP: cover property (group_irq);
endmodule
bind gpp_gpio_pint gpp_gpio_pint_asserts #(.NUM_PORTS(NUM_PORTS), .NUM_CH(NUM_CH)) u_chk (.clk, .rst, .ce,
  .wr, .rd, .rd_valid, .pin_out, .pin_oe, .pint_irq, .pm_evt_en, .cpu_event_notify, .event_pin, .group_irq,
  .power_mode, .wake_en, .wake_req);

// file: sim/gpp_gpio_pint_tb.sv
// testbench for the gpio port and pin interrupt block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module gpp_gpio_pint_tb;
  import gpp_pkg::*;
  typedef struct packed {gpp_loc_t loc; logic [3:0] be; logic [31:0] data, out, oe;} gpp_row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, grp_and = 1'b0, grp_edge = 1'b0, grp_clr = 1'b0;
  logic pm_enable = 1'b0, pm_stk_clr = 1'b0, pm_evt_en = 1'b0, wake_en = 1'b0;
  gpp_acc_t wr = '0, rd = '0;
  logic [63:0] pin_in = '0, pin_irq_en = '0, pin_irq_level = '0, pin_irq_pol = '0, pin_irq_clr = '0;
  logic [63:0] grp_en = '0, grp_pol = '0;
  gpp_pint_cfg_t [7:0] pint_cfg = '0;
  gpp_slice_cfg_t [7:0] slice_cfg = '0;
  logic [7:0] pint_clr = '0;
  gpp_pwr_t power_mode = GPP_PM_ACTIVE;
  logic [31:0] rd_data;
  logic [63:0] pin_out, pin_oe;
  logic [1:0] gpio_irq;
  logic [7:0] pint_irq;
  logic rd_valid, group_irq, cpu_event_notify, event_pin, wake_req;
  int n_errors = 0, n_compared = 0;
  // write rows on port 0 and the outputs they leave
  gpp_row_t rows [12] = '{
    '{GPP_LOC_OUT, 4'hF, 32'h12345678, 32'h12345678, 32'h0},
    '{GPP_LOC_SET, 4'hF, 32'h000000F0, 32'h123456F8, 32'h0},
    '{GPP_LOC_SET, 4'hF, 32'h00000000, 32'h123456F8, 32'h0},
    '{GPP_LOC_CLR, 4'hF, 32'h0000000F, 32'h123456F0, 32'h0},
    '{GPP_LOC_CLR, 4'h2, 32'hFFFFFFFF, 32'h123400F0, 32'h0},
    '{GPP_LOC_PIN, 4'hC, 32'hABCD0000, 32'hABCD00F0, 32'h0},
    '{GPP_LOC_MASK, 4'hF, 32'h0000FFFF, 32'hABCD00F0, 32'h0},
    '{GPP_LOC_MPIN, 4'hF, 32'h00000000, 32'h000000F0, 32'h0},
    '{GPP_LOC_MPIN, 4'hF, 32'hFFFFFFFF, 32'hFFFF00F0, 32'h0},
    '{gpp_loc_t'(3'h7), 4'hF, 32'h00000000, 32'hFFFF00F0, 32'h0},
    '{GPP_LOC_DIR, 4'hF, 32'hA5A5A5A5, 32'hFFFF00F0, 32'hA5A5A5A5},
    '{GPP_LOC_DIR, 4'h1, 32'h00000000, 32'hFFFF00F0, 32'hA5A5A500}};
  gpp_gpio_pint u_dut (.clk, .rst, .ce, .wr, .rd, .rd_data, .rd_valid, .pin_in, .pin_out, .pin_oe,
    .pin_irq_en, .pin_irq_level, .pin_irq_pol, .pin_irq_clr, .gpio_irq, .grp_en, .grp_pol, .grp_and,
    .grp_edge, .grp_clr, .group_irq, .pint_cfg, .pint_clr, .pm_enable, .slice_cfg, .pm_stk_clr, .pm_evt_en,
    .pint_irq, .cpu_event_notify, .event_pin, .power_mode, .wake_en, .wake_req);
  // 25 MHz clock
  always #20 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one write, then an idle cycle so the strobe is never re-raised in one step
  task automatic wr_acc(input logic p, input gpp_loc_t l, input logic [3:0] b, input logic [31:0] d);
    wr = '{en: 1'b1, port: p, loc: l, be: b, data: d};
    cyc(1);
    wr.en = 1'b0;
    cyc(1);
  endtask
  task automatic rd_acc(input gpp_loc_t l, input logic [3:0] b, output logic [31:0] d);
    rd = '{en: 1'b1, port: 1'b0, loc: l, be: b, data: '0};
    cyc(1);
    `CHK("rd_valid", 1'b1, rd_valid)
    d = rd_data;
    rd.en = 1'b0;
    cyc(1);
    `CHK("rd_valid low", 1'b0, rd_valid)
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // run is about 120 cycles, so 3000 cycles marks a hang
  initial begin
    #120000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] d;
    int cnt, cnt_pin;
    cyc(4);
    `CHK("pin_oe in reset", 64'h0, pin_oe)
    rst = 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      wr_acc(1'b0, rows[i].loc, rows[i].be, rows[i].data);
      `CHK("pin_out", rows[i].out, pin_out[31:0])
      `CHK("pin_oe", rows[i].oe, pin_oe[31:0])
    end
    wr_acc(1'b1, GPP_LOC_OUT, 4'hF, 32'h00000001);
    `CHK("pin_out port1", 64'h00000001FFFF00F0, pin_out)
    // readback of pad levels whatever the direction
    pin_in[31:0] = 32'h5A5A0F0F;
    cyc(3);
    rd_acc(GPP_LOC_PIN, 4'hF, d);
    `CHK("pin read", 32'h5A5A0F0F, d)
    wr_acc(1'b0, GPP_LOC_MASK, 4'hF, 32'hFFFF0000);
    rd_acc(GPP_LOC_MPIN, 4'hF, d);
    `CHK("masked read", 32'h00000F0F, d)
    rd_acc(GPP_LOC_PIN, 4'h1, d);
    `CHK("byte read", 32'h0000000F, d)
    rd_acc(gpp_loc_t'(3'h7), 4'hF, d);
    `CHK("unused read", 32'h0, d)
    // channels: rise, fall, both, high level, low level on pins 16..20
    pin_in = '0;
    pint_cfg[0] = '{6'd16, 1'b0, 1'b1, 1'b0};
    pint_cfg[1] = '{6'd17, 1'b0, 1'b0, 1'b1};
    pint_cfg[2] = '{6'd18, 1'b0, 1'b1, 1'b1};
    pint_cfg[3] = '{6'd19, 1'b1, 1'b1, 1'b0};
    pint_cfg[4] = '{6'd20, 1'b1, 1'b1, 1'b1};
    cyc(4);
    pint_clr = '1;
    cyc(1);
    pint_clr = '0;
    cyc(1);
    `CHK("pint quiet", 8'h10, pint_irq)
    pin_in[20:16] = 5'h1F;
    cyc(4);
    `CHK("pint rise", 8'h0D, pint_irq)
    wake_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      power_mode = gpp_pwr_t'(4'h1 << i);
      cyc(1);
      `CHK("wake_req", (i == 1 || i == 2), wake_req)
    end
    pint_clr = 8'h07;
    cyc(1);
    pint_clr = '0;
    pin_in[20:16] = 5'h00;
    cyc(4);
    `CHK("pint fall", 8'h16, pint_irq)
    // group of pins 16 and 17, pin 16 also as high-level pin interrupt
    pin_irq_en[16] = 1'b1;
    pin_irq_level[16] = 1'b1;
    pin_irq_pol[16] = 1'b1;
    grp_en[17:16] = 2'b11;
    grp_pol[17:16] = 2'b11;
    grp_and = 1'b1;
    pin_in[17:16] = 2'b11;
    cyc(4);
    `CHK("group all", 1'b1, group_irq)
    `CHK("gpio_irq", 2'b01, gpio_irq)
    pin_in[16] = 1'b0;
    cyc(4);
    `CHK("group all off", 1'b0, group_irq)
    `CHK("gpio_irq off", 2'b00, gpio_irq)
    grp_and = 1'b0;
    cyc(1);
    `CHK("group any", 1'b1, group_irq)
    // group edge mode: clear the old rise, then a new rise of the combination
    grp_edge = 1'b1;
    grp_clr = 1'b1;
    cyc(1);
    grp_clr = 1'b0;
    pin_in[17] = 1'b0;
    cyc(4);
    `CHK("group edge clear", 1'b0, group_irq)
    pin_in[17] = 1'b1;
    cyc(4);
    `CHK("group edge", 1'b1, group_irq)
    // per-pin edge mode: pin 16 falling only, pin 17 rising only
    pin_irq_level[17:16] = 2'b00;
    pin_irq_pol[17:16] = 2'b10;
    pin_irq_en[17] = 1'b1;
    pin_in[17:16] = 2'b01;
    cyc(4);
    `CHK("gpio edge wrong way", 2'b00, gpio_irq)
    pin_in[17:16] = 2'b10;
    cyc(4);
    `CHK("gpio edge", 2'b01, gpio_irq)
    pin_irq_clr[17:16] = 2'b11;
    cyc(1);
    pin_irq_clr = '0;
    cyc(1);
    `CHK("gpio edge clear", 2'b00, gpio_irq)
    // pattern: slice0 = p16, slices 1-2 = p17 and not p18
    pm_enable = 1'b1;
    pm_evt_en = 1'b1;
    for (int i = 0; i < 8; i++) slice_cfg[i] = '{3'(i), GPP_PM_NEVER, 1'b1};
    slice_cfg[0] = '{3'd0, GPP_PM_HIGH, 1'b1};
    slice_cfg[1] = '{3'd1, GPP_PM_HIGH, 1'b0};
    slice_cfg[2] = '{3'd2, GPP_PM_LOW, 1'b1};
    pin_in[17] = 1'b0;
    cyc(4);
    `CHK("pattern none", 8'h00, pint_irq)
    pin_in[16] = 1'b1;
    cnt = 0;
    cnt_pin = 0;
    repeat (6) begin
      cyc(1);
      cnt += (cpu_event_notify === 1'b1);
      cnt_pin += (event_pin === 1'b1);
    end
    `CHK("event pulses", 1, cnt)
    `CHK("event pad pulses", 1, cnt_pin)
    `CHK("pattern slice0", 8'h01, pint_irq)
    pin_in[17] = 1'b1;
    cyc(4);
    `CHK("pattern chain", 8'h05, pint_irq)
    // sticky rise on pin 19 holds after the pin falls again
    slice_cfg[3] = '{3'd3, GPP_PM_STK_RISE, 1'b1};
    pm_stk_clr = 1'b1;
    cyc(1);
    pm_stk_clr = 1'b0;
    cyc(1);
    `CHK("sticky clear", 8'h05, pint_irq)
    pin_in[19] = 1'b1;
    cyc(3);
    pin_in[19] = 1'b0;
    cyc(4);
    `CHK("sticky rise", 8'h0D, pint_irq)
    power_mode = GPP_PM_STANDBY;
    cyc(1);
    `CHK("pattern wake", 1'b1, wake_req)
    power_mode = GPP_PM_DEEP;
    cyc(1);
    `CHK("pattern no deep wake", 1'b0, wake_req)
    // reset in mid-run returns all pins to inputs
    rst = 1'b1;
    cyc(1);
    `CHK("pin_oe reset", 64'h0, pin_oe)
    `CHK("pin_out reset", 64'h0, pin_out)
    rst = 1'b0;
    wr_acc(1'b0, GPP_LOC_DIR, 4'h3, 32'h0000FFFF);
    `CHK("pin_oe after reset", 64'h000000000000FFFF, pin_oe)
    tally_and_finish();
  end
endmodule

// file: src/gpp_gpio_pint.sv
// gpio ports with per-pin and group interrupts, pin interrupt and pattern match engine
`timescale 1ns/1ps
module gpp_gpio_pint #(
  parameter int NUM_PORTS = gpp_pkg::GPP_NUM_PORTS,
  parameter int NUM_CH = gpp_pkg::GPP_NUM_CH
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire gpp_pkg::gpp_acc_t wr, // port write access
  input wire gpp_pkg::gpp_acc_t rd, // port read access (data unused)
  output logic [gpp_pkg::GPP_PORT_W-1:0] rd_data, // read data
  output logic rd_valid, // read data valid pulse
  input wire logic [NUM_PORTS*32-1:0] pin_in, // pad input levels
  output logic [NUM_PORTS*32-1:0] pin_out, // pad output levels
  output logic [NUM_PORTS*32-1:0] pin_oe, // pad output enables, high drives
  input wire logic [NUM_PORTS*32-1:0] pin_irq_en, // per-pin interrupt enable
  input wire logic [NUM_PORTS*32-1:0] pin_irq_level, // 1 level, 0 edge
  input wire logic [NUM_PORTS*32-1:0] pin_irq_pol, // 1 high/rising, 0 low/falling
  input wire logic [NUM_PORTS*32-1:0] pin_irq_clr, // clear edge status pulse
  output logic [NUM_PORTS-1:0] gpio_irq, // per-port interrupt
  input wire logic [NUM_PORTS*32-1:0] grp_en, // group member pins
  input wire logic [NUM_PORTS*32-1:0] grp_pol, // group active level
  input wire logic grp_and, // 1 all members, 0 any member
  input wire logic grp_edge, // 1 edge on combination, 0 level
  input wire logic grp_clr, // clear group edge status
  output logic group_irq, // group interrupt
  input wire gpp_pkg::gpp_pint_cfg_t [NUM_CH-1:0] pint_cfg, // channel setup
  input wire logic [NUM_CH-1:0] pint_clr, // clear channel edge status
  input wire logic pm_enable, // 1 lines driven by pattern slices
  input wire gpp_pkg::gpp_slice_cfg_t [NUM_CH-1:0] slice_cfg, // slice setup
  input wire logic pm_stk_clr, // clear sticky slice edges
  input wire logic pm_evt_en, // enable cpu event on match
  output logic [NUM_CH-1:0] pint_irq, // lines to processor_interrupt_controller
  output logic cpu_event_notify, // event pulse to cpu
  output logic event_pin, // event copy for a pad
  input wire gpp_pkg::gpp_pwr_t power_mode, // current power mode
  input wire logic wake_en, // allow pin interrupt wake
  output logic wake_req // wake request to power control
);
  import gpp_pkg::*;

  // total pin count over all ports
  localparam int NP = NUM_PORTS * 32;

  // port registers
  logic [NUM_PORTS-1:0][31:0] dir_q;
  logic [NUM_PORTS-1:0][31:0] out_q;
  logic [NUM_PORTS-1:0][31:0] mask_q;

  // pin synchroniser and per-pin interrupt state
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;
  logic [NP-1:0] prev_q;
  logic [NP-1:0] pin_stat_q;
  logic [NP-1:0] pin_act;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;

  // group interrupt state
  logic grp_now;
  logic grp_prev_q;
  logic grp_stat_q;

  // pin channel and sticky edge state
  logic [NUM_CH-1:0] ch_lvl;
  logic [NUM_CH-1:0] ch_prev_q;
  logic [NUM_CH-1:0] ch_stat_q;
  logic [NUM_CH-1:0] ch_irq;
  logic [NUM_CH-1:0] stk_rise_q;
  logic [NUM_CH-1:0] stk_fall_q;

  // pattern slices and cpu event
  logic [NUM_CH-1:0] term;
  logic [NUM_CH-1:0] slice_irq;
  logic any_match;
  logic match_prev_q;
  logic evt_q;

  // read path
  logic [31:0] rd_d;

  // lane expansion of byte enables
  function automatic logic [31:0] lane_mask(input logic [GPP_LANES-1:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < GPP_LANES; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // merge new bits into old where sel is high
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] sel);
    return (old & ~sel) | (nw & sel);
  endfunction

  // two-flop pin synchroniser, second stage feeds all logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // edges seen between the last two synchronised samples
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // direction registers, inputs after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= {NUM_PORTS{GPP_DIR_RST}};
    end else if (ce && wr.en && wr.loc == GPP_LOC_DIR) begin
      dir_q[wr.port] <= merge(dir_q[wr.port], wr.data, lane_mask(wr.be));
    end
  end

  // mask registers, a set bit excludes that pin from masked accesses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= {NUM_PORTS{GPP_MASK_RST}};
    end else if (ce && wr.en && wr.loc == GPP_LOC_MASK) begin
      mask_q[wr.port] <= merge(mask_q[wr.port], wr.data, lane_mask(wr.be));
    end
  end

  // output registers: whole, masked, set and clear writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= {NUM_PORTS{GPP_OUT_RST}};
    end else if (ce && wr.en) begin
      unique case (wr.loc)
        GPP_LOC_PIN, GPP_LOC_OUT: begin
          out_q[wr.port] <= merge(out_q[wr.port], wr.data, lane_mask(wr.be));
        end
        GPP_LOC_MPIN: begin
          out_q[wr.port] <= merge(out_q[wr.port], wr.data, lane_mask(wr.be) & ~mask_q[wr.port]);
        end
        GPP_LOC_SET: begin
          out_q[wr.port] <= out_q[wr.port] | (wr.data & lane_mask(wr.be));
        end
        GPP_LOC_CLR: begin
          out_q[wr.port] <= out_q[wr.port] & ~(wr.data & lane_mask(wr.be));
        end
        default: begin
          out_q[wr.port] <= out_q[wr.port];
        end
      endcase
    end
  end

  // pads driven from registers
  assign pin_out = out_q;
  assign pin_oe = dir_q;

  // read mux, pins read from the synchroniser regardless of function
  always_comb begin
    rd_d = 32'h00000000;
    unique case (rd.loc)
      GPP_LOC_DIR: rd_d = dir_q[rd.port];
      GPP_LOC_MASK: rd_d = mask_q[rd.port];
      GPP_LOC_PIN: rd_d = sync2_q[rd.port*32 +: 32];
      GPP_LOC_MPIN: rd_d = sync2_q[rd.port*32 +: 32] & ~mask_q[rd.port];
      GPP_LOC_OUT, GPP_LOC_SET, GPP_LOC_CLR: rd_d = out_q[rd.port];
      default: rd_d = 32'h00000000;
    endcase
    rd_d = rd_d & lane_mask(rd.be);
  end

  // registered read answer one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h00000000;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd.en;
      if (rd.en) begin
        rd_data <= rd_d;
      end
    end
  end

  // per-pin edge select, bit by bit: polarity high takes rising, low takes falling
  assign pin_act = pin_irq_en & ((pin_irq_pol & rise) | (~pin_irq_pol & fall));

  // per-pin edge status, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_stat_q <= '0;
    end else if (ce) begin
      pin_stat_q <= (pin_stat_q & ~pin_irq_clr) | (pin_act & ~pin_irq_level);
    end
  end

  // per-port interrupt lines from edge status or live level
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_irq
    assign gpio_irq[p] = |((pin_stat_q[p*32 +: 32] & ~pin_irq_level[p*32 +: 32])
                          | (pin_irq_en[p*32 +: 32] & pin_irq_level[p*32 +: 32]
                             & ~(sync2_q[p*32 +: 32] ^ pin_irq_pol[p*32 +: 32])));
  end

  // group combination of selected pins
  always_comb begin
    if (grp_and) begin
      grp_now = (|grp_en) && ((grp_en & ~(sync2_q ^ grp_pol)) == grp_en);
    end else begin
      grp_now = |(grp_en & ~(sync2_q ^ grp_pol));
    end
  end

  // group edge status, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grp_prev_q <= 1'b0;
      grp_stat_q <= 1'b0;
    end else if (ce) begin
      grp_prev_q <= grp_now;
      grp_stat_q <= (grp_stat_q & ~grp_clr) | (grp_now & ~grp_prev_q);
    end
  end

  // group line: latched rise in edge mode, live combination otherwise
  assign group_irq = grp_edge ? grp_stat_q : grp_now;

  // pin interrupt channels pick any pin of ports 0 and 1
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    assign ch_lvl[c] = sync2_q[pint_cfg[c].sel];
    // level: rise_en enables, fall_en picks low-active
    assign ch_irq[c] = pint_cfg[c].level ? (pint_cfg[c].rise_en & (ch_lvl[c] ^ pint_cfg[c].fall_en))
                                         : ch_stat_q[c];
  end

  // channel edge status and slice sticky edges, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_prev_q <= '0;
      ch_stat_q <= '0;
      stk_rise_q <= '0;
      stk_fall_q <= '0;
    end else if (ce) begin
      ch_prev_q <= ch_lvl;
      for (int c = 0; c < NUM_CH; c++) begin
        ch_stat_q[c] <= (ch_stat_q[c] & ~pint_clr[c]) | (~pint_cfg[c].level
                        & ((pint_cfg[c].rise_en & ch_lvl[c] & ~ch_prev_q[c])
                           | (pint_cfg[c].fall_en & ~ch_lvl[c] & ch_prev_q[c])));
      end
      stk_rise_q <= (stk_rise_q & {NUM_CH{~pm_stk_clr}}) | (ch_lvl & ~ch_prev_q);
      stk_fall_q <= (stk_fall_q & {NUM_CH{~pm_stk_clr}}) | (~ch_lvl & ch_prev_q);
    end
  end

  // pattern slices: product terms chained until an endpoint
  for (genvar s = 0; s < NUM_CH; s++) begin : g_slice
    logic cond;
    logic [2:0] src;
    assign src = slice_cfg[s].src;
    always_comb begin
      cond = 1'b0;
      unique case (slice_cfg[s].cond)
        GPP_PM_ALWAYS: cond = 1'b1;
        GPP_PM_STK_RISE: cond = stk_rise_q[src];
        GPP_PM_STK_FALL: cond = stk_fall_q[src];
        GPP_PM_STK_ANY: cond = stk_rise_q[src] | stk_fall_q[src];
        GPP_PM_HIGH: cond = ch_lvl[src];
        GPP_PM_LOW: cond = ~ch_lvl[src];
        GPP_PM_NEVER: cond = 1'b0;
        GPP_PM_EVENT: cond = ch_lvl[src] ^ ch_prev_q[src];
      endcase
    end
    if (s == 0) begin : g_first
      assign term[s] = cond;
    end else begin : g_next
      assign term[s] = cond & (slice_cfg[s-1].endpoint | term[s-1]);
    end
    assign slice_irq[s] = slice_cfg[s].endpoint & term[s];
  end

  // channel lines come from the slices when the pattern engine is on
  assign pint_irq = pm_enable ? slice_irq : ch_irq;
  assign any_match = pm_enable & (|slice_irq);

  // one-cycle cpu event on each new match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_prev_q <= 1'b0;
      evt_q <= 1'b0;
    end else if (ce) begin
      match_prev_q <= any_match;
      evt_q <= pm_evt_en & any_match & ~match_prev_q;
    end
  end

  // one registered pulse feeds both the cpu and the pad
  assign cpu_event_notify = evt_q;
  assign event_pin = evt_q;

  // wake only from idle or standby
  assign wake_req = wake_en & (|pint_irq)
                    & (power_mode == GPP_PM_IDLE || power_mode == GPP_PM_STANDBY);
endmodule

// file: src/gpp_pkg.sv
// package for the gpio port and pin interrupt / pattern match block
// Operation
// - all pins are inputs after reset
// - set and clear locations change many bits
// - pin levels readable whatever function is selected
// - mask makes masked accesses skip unselected bits
// - byte and halfword lanes affect only themselves
// - whole-port write updates every output bit
// - up to 64 pins across ports
// - each pin raises edge or level interrupt
// - chosen pin combination raises one group interrupt
// - eight selectable pin interrupts, separate lines
// - edge channels trigger rising, falling or both
// - level channels active high or active low
// - pin interrupts request wake from idle, standby
// - pattern engine combines eight pins into expression
// - each bit slice has its own interrupt
// - pattern match pulses cpu event, also to pin
// - pattern wakes only from idle and standby
// - source selection independent of pin function
// - control accesses complete in one cycle
package gpp_pkg;
  localparam int GPP_PORT_W = 32;
  localparam int GPP_NUM_PORTS = 2;
  localparam int GPP_NUM_PINS = 64;
  localparam int GPP_SEL_W = 6;
  localparam int GPP_NUM_CH = 8;
  localparam int GPP_LANES = 4;
  localparam logic [GPP_PORT_W-1:0] GPP_DIR_RST = 32'h00000000;
  localparam logic [GPP_PORT_W-1:0] GPP_OUT_RST = 32'h00000000;
  localparam logic [GPP_PORT_W-1:0] GPP_MASK_RST = 32'h00000000;

  // port access locations
  typedef enum logic [2:0] {
    GPP_LOC_DIR = 3'h0,
    GPP_LOC_MASK = 3'h1,
    GPP_LOC_PIN = 3'h2,
    GPP_LOC_MPIN = 3'h3,
    GPP_LOC_SET = 3'h4,
    GPP_LOC_CLR = 3'h5,
    GPP_LOC_OUT = 3'h6
  } gpp_loc_t;

  // pattern slice conditions
  localparam logic [2:0] GPP_PM_ALWAYS = 3'h0;
  localparam logic [2:0] GPP_PM_STK_RISE = 3'h1;
  localparam logic [2:0] GPP_PM_STK_FALL = 3'h2;
  localparam logic [2:0] GPP_PM_STK_ANY = 3'h3;
  localparam logic [2:0] GPP_PM_HIGH = 3'h4;
  localparam logic [2:0] GPP_PM_LOW = 3'h5;
  localparam logic [2:0] GPP_PM_NEVER = 3'h6;
  localparam logic [2:0] GPP_PM_EVENT = 3'h7;

  // power modes seen by the wake logic
  typedef enum logic [3:0] {
    GPP_PM_ACTIVE = 4'h1,
    GPP_PM_IDLE = 4'h2,
    GPP_PM_STANDBY = 4'h4,
    GPP_PM_DEEP = 4'h8
  } gpp_pwr_t;

  typedef struct packed {
    logic en;
    logic [$clog2(GPP_NUM_PORTS)-1:0] port;
    gpp_loc_t loc;
    logic [GPP_LANES-1:0] be;
    logic [GPP_PORT_W-1:0] data;
  } gpp_acc_t;

  typedef struct packed {
    logic [GPP_SEL_W-1:0] sel;
    logic level;
    logic rise_en;
    logic fall_en;
  } gpp_pint_cfg_t;

  typedef struct packed {
    logic [2:0] src;
    logic [2:0] cond;
    logic endpoint;
  } gpp_slice_cfg_t;
endpackage
